/* aaie_exec.sv */
// add/and instruction execute unit with register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module aaie_exec #(
  parameter int AXI_ADDR_W = 8,
  parameter int DMEM_ADDR_W = 12
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // register bus
  input  wire logic [AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // instruction fetch
  input  wire logic [15:0]            instr_word,
  input  wire logic                   instr_valid,
  output logic                        instr_ready,
  output logic [1:0]                  phase,
  // banked data memory
  output logic [DMEM_ADDR_W-1:0]      dmem_addr,
  output logic                        dmem_rd_en,
  input  wire logic [7:0]             dmem_rdata,
  output logic                        dmem_wr_en,
  output logic [7:0]                  dmem_wdata
);

  initial begin
    if (AXI_ADDR_W < 4 || AXI_ADDR_W > 8) begin
      $error("aaie_exec: AXI_ADDR_W must be 4 to 8");
    end
    if (DMEM_ADDR_W != 12) begin
      $error("aaie_exec: DMEM_ADDR_W must be 12");
    end
  end

  aaie_pkg::aaie_phase_e          phase_q;
  aaie_pkg::aaie_op_e             op_q;
  aaie_pkg::aaie_op_e             op_d;
  logic                           active_q;
  logic                           dest_file_q;
  logic [7:0]                     lit_q;
  logic [7:0]                     result_q;
  logic [aaie_pkg::FLAG_W-1:0]    flags_q;
  logic [aaie_pkg::FLAG_W-1:0]    upd_q;
  logic [7:0]                     working_register_q;
  logic [aaie_pkg::FLAG_W-1:0]    status_q;
  logic [3:0]                     bank_select_register_q;
  logic                           unknown_q;
  logic [DMEM_ADDR_W-1:0]         dmem_addr_q;
  logic                           dmem_rd_en_q;
  logic                           dmem_wr_en_q;
  logic [7:0]                     dmem_wdata_q;
  logic [7:0]                     alu_result;
  logic [aaie_pkg::FLAG_W-1:0]    alu_flags;
  logic [aaie_pkg::FLAG_W-1:0]    alu_upd;
  logic                           take;
  logic                           commit;
  logic                           file_op_d;
  logic [11:0]                    addr_d;
  logic                           aw_got_q;
  logic                           w_got_q;
  logic [7:0]                     aw_addr_q;
  logic [31:0]                    w_data_q;
  logic                           w_lane0_q;
  logic                           wr_fire;
  logic                           wr_hit;
  logic                           bvalid_q;
  logic [1:0]                     bresp_q;
  logic                           rvalid_q;
  logic [31:0]                    rdata_q;
  logic [1:0]                     rresp_q;
  logic [7:0]                     rd_addr;

  // fetch handshake and phase
  assign instr_ready = (phase_q == aaie_pkg::PH_Q1);
  assign take        = instr_ready && instr_valid;
  assign phase       = phase_q;
  assign commit      = active_q && (phase_q == aaie_pkg::PH_Q4);

  // opcode decode
  always_comb begin
    op_d      = aaie_pkg::OP_NONE;
    file_op_d = 1'b0;
    if (instr_word[15:8] == aaie_pkg::OPC_ADD_LITERAL) begin
      op_d = aaie_pkg::OP_ADD_LITERAL;
    end else if (instr_word[15:8] == aaie_pkg::OPC_AND_LITERAL) begin
      op_d = aaie_pkg::OP_AND_LITERAL;
    end else if (instr_word[15:10] == aaie_pkg::OPC_ADD_WORK_FILE) begin
      op_d      = aaie_pkg::OP_ADD_WORK_FILE;
      file_op_d = 1'b1;
    end else if (instr_word[15:10] == aaie_pkg::OPC_ADD_WITH_CARRY) begin
      op_d      = aaie_pkg::OP_ADD_WITH_CARRY;
      file_op_d = 1'b1;
    end else if (instr_word[15:10] == aaie_pkg::OPC_AND_WORK_FILE) begin
      op_d      = aaie_pkg::OP_AND_WORK_FILE;
      file_op_d = 1'b1;
    end
  end

  // operand bank selection
  always_comb begin
    if (instr_word[aaie_pkg::OPC_ACCESS_BIT]) begin
      addr_d = {bank_select_register_q, instr_word[7:0]};
    end else if (instr_word[7:0] < aaie_pkg::ACCESS_SPLIT) begin
      addr_d = {aaie_pkg::ACCESS_LOW_BANK, instr_word[7:0]};
    end else begin
      addr_d = {aaie_pkg::ACCESS_HIGH_BANK, instr_word[7:0]};
    end
  end

  // four phase sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q <= aaie_pkg::PH_Q1;
    end else begin
      case (phase_q)
        aaie_pkg::PH_Q1: phase_q <= aaie_pkg::PH_Q2;
        aaie_pkg::PH_Q2: phase_q <= aaie_pkg::PH_Q3;
        aaie_pkg::PH_Q3: phase_q <= aaie_pkg::PH_Q4;
        default:         phase_q <= aaie_pkg::PH_Q1;
      endcase
    end
  end

  // decode latch in the first phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_q    <= 1'b0;
      op_q        <= aaie_pkg::OP_NONE;
      dest_file_q <= 1'b0;
      lit_q       <= 8'h00;
      dmem_addr_q <= '0;
    end else if (phase_q == aaie_pkg::PH_Q1) begin
      active_q    <= take && (op_d != aaie_pkg::OP_NONE);
      op_q        <= take ? op_d : aaie_pkg::OP_NONE;
      dest_file_q <= file_op_d && instr_word[aaie_pkg::OPC_DEST_BIT];
      lit_q       <= instr_word[7:0];
      if (take && file_op_d) begin
        dmem_addr_q <= addr_d;
      end
    end
  end

  // operand read strobe in the second phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dmem_rd_en_q <= 1'b0;
    end else begin
      dmem_rd_en_q <= take && file_op_d;
    end
  end

  aaie_alu u_alu (
    .work_val (working_register_q),
    .operand  ((op_q == aaie_pkg::OP_ADD_LITERAL || op_q == aaie_pkg::OP_AND_LITERAL) ? lit_q : dmem_rdata),
    .carry_in (status_q[aaie_pkg::FLAG_CARRY]),
    .op       (op_q),
    .result   (alu_result),
    .flags    (alu_flags),
    .flag_upd (alu_upd)
  );

  // compute in the third phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_q     <= 8'h00;
      flags_q      <= '0;
      upd_q        <= '0;
      dmem_wr_en_q <= 1'b0;
      dmem_wdata_q <= 8'h00;
    end else if (phase_q == aaie_pkg::PH_Q3 && active_q) begin
      result_q     <= alu_result;
      flags_q      <= alu_flags;
      upd_q        <= alu_upd;
      dmem_wr_en_q <= dest_file_q;
      dmem_wdata_q <= alu_result;
    end else begin
      dmem_wr_en_q <= 1'b0;
    end
  end

  assign dmem_addr  = dmem_addr_q;
  assign dmem_rd_en = dmem_rd_en_q;
  assign dmem_wr_en = dmem_wr_en_q;
  assign dmem_wdata = dmem_wdata_q;

  // register write channel
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;
  assign wr_hit        = wr_fire && w_lane0_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= aaie_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q   <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        if (aw_addr_q == aaie_pkg::REG_WORKING || aw_addr_q == aaie_pkg::REG_STATUS ||
            aw_addr_q == aaie_pkg::REG_BANK_SELECT || aw_addr_q == aaie_pkg::REG_EXEC) begin
          bresp_q <= aaie_pkg::RESP_OKAY;
        end else begin
          bresp_q <= aaie_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready && bvalid_q) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // working register, execution wins over software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      working_register_q <= aaie_pkg::RST_WORKING;
    end else if (commit && !dest_file_q) begin
      working_register_q <= result_q;
    end else if (wr_hit && aw_addr_q == aaie_pkg::REG_WORKING) begin
      working_register_q <= w_data_q[7:0];
    end
  end

  // status flags, only the updated ones change on commit, a software write loads all of them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_q <= aaie_pkg::RST_STATUS;
    end else if (commit) begin
      status_q <= (status_q & ~upd_q) | (flags_q & upd_q);
    end else if (wr_hit && aw_addr_q == aaie_pkg::REG_STATUS) begin
      status_q <= w_data_q[aaie_pkg::FLAG_W-1:0];
    end
  end

  // bank select register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bank_select_register_q <= aaie_pkg::RST_BANK_SELECT;
    end else if (wr_hit && aw_addr_q == aaie_pkg::REG_BANK_SELECT) begin
      bank_select_register_q <= w_data_q[3:0];
    end
  end

  // unknown opcode sticky flag, set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unknown_q <= 1'b0;
    end else if (take && op_d == aaie_pkg::OP_NONE) begin
      unknown_q <= 1'b1;
    end else if (wr_hit && aw_addr_q == aaie_pkg::REG_EXEC && w_data_q[aaie_pkg::EXEC_UNKNOWN]) begin
      unknown_q <= 1'b0;
    end
  end

  // register read channel
  assign s_axi_arready = !rvalid_q;
  assign rd_addr       = 8'(s_axi_araddr);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= aaie_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= aaie_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      if (rd_addr == aaie_pkg::REG_WORKING) begin
        rdata_q[7:0] <= working_register_q;
      end else if (rd_addr == aaie_pkg::REG_STATUS) begin
        rdata_q[aaie_pkg::FLAG_W-1:0] <= status_q;
      end else if (rd_addr == aaie_pkg::REG_BANK_SELECT) begin
        rdata_q[3:0] <= bank_select_register_q;
      end else if (rd_addr == aaie_pkg::REG_EXEC) begin
        rdata_q[aaie_pkg::EXEC_BUSY]                            <= active_q;
        rdata_q[aaie_pkg::EXEC_UNKNOWN]                         <= unknown_q;
        rdata_q[aaie_pkg::EXEC_RESULT_LSB+7:aaie_pkg::EXEC_RESULT_LSB] <= result_q;
      end else begin
        rresp_q <= aaie_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready && rvalid_q) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule

`default_nettype wire

/* aaie_pkg.sv */
// constants, opcodes and register map for the add/and execute block
package aaie_pkg;

  // instruction phases, gray order along the cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } aaie_phase_e;

  // decoded operations
  typedef enum logic [2:0] {
    OP_NONE           = 3'h0,
    OP_ADD_LITERAL    = 3'h1,
    OP_ADD_WORK_FILE  = 3'h2,
    OP_ADD_WITH_CARRY = 3'h3,
    OP_AND_LITERAL    = 3'h4,
    OP_AND_WORK_FILE  = 3'h5
  } aaie_op_e;

  // opcode patterns
  localparam logic [7:0] OPC_ADD_LITERAL    = 8'h0F;
  localparam logic [7:0] OPC_AND_LITERAL    = 8'h0B;
  localparam logic [5:0] OPC_ADD_WORK_FILE  = 6'h09;
  localparam logic [5:0] OPC_ADD_WITH_CARRY = 6'h08;
  localparam logic [5:0] OPC_AND_WORK_FILE  = 6'h05;
  localparam int         OPC_DEST_BIT       = 9;
  localparam int         OPC_ACCESS_BIT     = 8;

  // access bank split and fixed banks
  localparam logic [7:0] ACCESS_SPLIT       = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK    = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK   = 4'hF;

  // flag positions in the status register
  localparam int         FLAG_CARRY         = 0;
  localparam int         FLAG_NIBBLE        = 1;
  localparam int         FLAG_ZERO          = 2;
  localparam int         FLAG_WRAP          = 3;
  localparam int         FLAG_NEG           = 4;
  localparam int         FLAG_W             = 5;

  // register byte offsets
  localparam logic [7:0] REG_WORKING        = 8'h00;
  localparam logic [7:0] REG_STATUS         = 8'h04;
  localparam logic [7:0] REG_BANK_SELECT    = 8'h08;
  localparam logic [7:0] REG_EXEC           = 8'h0C;

  // exec register fields
  localparam int         EXEC_BUSY          = 0;
  localparam int         EXEC_UNKNOWN       = 1;
  localparam int         EXEC_RESULT_LSB    = 8;

  // reset values
  localparam logic [7:0] RST_WORKING        = 8'h00;
  localparam logic [4:0] RST_STATUS         = 5'h00;
  localparam logic [3:0] RST_BANK_SELECT    = 4'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY          = 2'b00;
  localparam logic [1:0] RESP_SLVERR        = 2'b10;

endpackage

/* aaie_alu.sv */
// adder and logic unit with flag generation
`timescale 1ns/1ps
`default_nettype none

module aaie_alu (
  // operands
  input  wire logic [7:0]             work_val,
  input  wire logic [7:0]             operand,
  input  wire logic                   carry_in,
  input  wire aaie_pkg::aaie_op_e     op,
  // results
  output logic [7:0]                  result,
  output logic [aaie_pkg::FLAG_W-1:0] flags,
  output logic [aaie_pkg::FLAG_W-1:0] flag_upd
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic       cin;

  always_comb begin
    cin      = (op == aaie_pkg::OP_ADD_WITH_CARRY) ? carry_in : 1'b0;
    sum      = {1'b0, work_val} + {1'b0, operand} + {8'h00, cin};
    low_sum  = {1'b0, work_val[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
    result   = 8'h00;
    flags    = '0;
    flag_upd = '0;
    case (op)
      aaie_pkg::OP_ADD_LITERAL,
      aaie_pkg::OP_ADD_WORK_FILE,
      aaie_pkg::OP_ADD_WITH_CARRY: begin
        result                       = sum[7:0];
        flags[aaie_pkg::FLAG_CARRY]  = sum[8];
        flags[aaie_pkg::FLAG_NIBBLE] = low_sum[4];
        flags[aaie_pkg::FLAG_WRAP]   = (work_val[7] == operand[7]) && (sum[7] != work_val[7]);
        flags[aaie_pkg::FLAG_ZERO]   = (sum[7:0] == 8'h00);
        flags[aaie_pkg::FLAG_NEG]    = sum[7];
        flag_upd                     = '1;
      end
      aaie_pkg::OP_AND_LITERAL,
      aaie_pkg::OP_AND_WORK_FILE: begin
        result                       = work_val & operand;
        flags[aaie_pkg::FLAG_ZERO]   = ((work_val & operand) == 8'h00);
        flags[aaie_pkg::FLAG_NEG]    = result[7];
        flag_upd[aaie_pkg::FLAG_ZERO] = 1'b1;
        flag_upd[aaie_pkg::FLAG_NEG]  = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

endmodule

`default_nettype wire

/* aaie_exec_checker.sv */
// assertions on the execute block ports
`timescale 1ns/1ps
`default_nettype none

module aaie_exec_checker #(
  parameter int DMEM_ADDR_W = 12
) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // instruction fetch
  input wire logic [15:0]            instr_word,
  input wire logic                   instr_valid,
  input wire logic                   instr_ready,
  input wire logic [1:0]             phase,
  // data memory
  input wire logic [DMEM_ADDR_W-1:0] dmem_addr,
  input wire logic                   dmem_rd_en,
  input wire logic                   dmem_wr_en,
  // register bus
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [7:0] f_q;
  wire        take = instr_valid && instr_ready;
  wire  [5:0] opc  = instr_word[15:10];
  wire        fop  = take && (opc == aaie_pkg::OPC_ADD_WORK_FILE || opc == aaie_pkg::OPC_ADD_WITH_CARRY
                     || opc == aaie_pkg::OPC_AND_WORK_FILE);
  wire        lop  = take && (instr_word[15:8] == aaie_pkg::OPC_ADD_LITERAL
                     || instr_word[15:8] == aaie_pkg::OPC_AND_LITERAL);

  // file address of the instruction just taken
  always_ff @(posedge ref_clk) begin
    f_q <= instr_word[7:0];
  end

  a_phase_walk: assert property (phase == 2'b00 |=> phase == 2'b01 ##1 phase == 2'b11 ##1 phase == 2'b10)
    else $error("phase order broken");
  a_read_q2: assert property (dmem_rd_en |-> phase == 2'b01)
    else $error("read strobe outside Q2");
  a_write_q4: assert property (dmem_wr_en |-> phase == 2'b10)
    else $error("write strobe outside Q4");
  a_file_read: assert property (fop |=> dmem_rd_en)
    else $error("file operand not read");
  a_literal_quiet: assert property (lop |=> !dmem_rd_en ##2 !dmem_wr_en)
    else $error("literal op touched memory");
  a_dest_work: assert property (fop && !instr_word[9] |=> !dmem_wr_en [*3])
    else $error("memory written with d=0");
  a_dest_file: assert property (fop && instr_word[9] |-> ##3 dmem_wr_en)
    else $error("memory not written with d=1");
  a_access_low: assert property (fop && !instr_word[8] && !instr_word[7]
    |=> dmem_addr == DMEM_ADDR_W'({aaie_pkg::ACCESS_LOW_BANK, f_q}))
    else $error("low access bank address wrong");
  a_access_high: assert property (fop && !instr_word[8] && instr_word[7]
    |=> dmem_addr == DMEM_ADDR_W'({aaie_pkg::ACCESS_HIGH_BANK, f_q}))
    else $error("high access bank address wrong");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
endmodule

bind aaie_exec aaie_exec_checker #(.DMEM_ADDR_W(DMEM_ADDR_W)) aaie_exec_checker_i (
  .ref_clk(ref_clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .phase(phase), .dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en),
  .dmem_wr_en(dmem_wr_en), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid)
);

`default_nettype wire

/* aaie_dmem_model.sv */
// banked data memory model facing the execute block
`timescale 1ns/1ps
`default_nettype none

module aaie_dmem_model (
  // clock
  input  wire logic        ref_clk,
  // memory port
  input  wire logic [11:0] dmem_addr,
  input  wire logic        dmem_rd_en,
  output logic [7:0]       dmem_rdata,
  input  wire logic        dmem_wr_en,
  input  wire logic [7:0]  dmem_wdata
);
  logic [7:0] mem [0:4095];

  initial dmem_rdata = 8'h5A;

  // read data registered at the end of Q2, inverted on every cycle without a read strobe
  always @(posedge ref_clk) begin
    if (dmem_rd_en) begin
      dmem_rdata <= mem[dmem_addr];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
    if (dmem_wr_en) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule

`default_nettype wire

/* tb_aaie_exec.sv */
// self-checking testbench for the execute block
`timescale 1ns/1ps
`default_nettype none

module tb_aaie_exec;
  logic        ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ivalid, iready, rd_en, wr_en;
  logic [7:0]  awaddr, araddr, mrdata, mwdata;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, phase;
  logic [15:0] iword;
  logic [11:0] maddr;
  int          errors, compares;

  aaie_exec aaie_exec_i (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr_word(iword), .instr_valid(ivalid),
    .instr_ready(iready), .phase(phase), .dmem_addr(maddr), .dmem_rd_en(rd_en), .dmem_rdata(mrdata),
    .dmem_wr_en(wr_en), .dmem_wdata(mwdata)
  );

  aaie_dmem_model aaie_dmem_model_i (
    .ref_clk(ref_clk), .dmem_addr(maddr), .dmem_rd_en(rd_en), .dmem_rdata(mrdata),
    .dmem_wr_en(wr_en), .dmem_wdata(mwdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        chk(bresp, 2'b00, "write response");
        break;
      end
    end
    if (n == 64) chk(0, 1, "write hang");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    if (n == 64) chk(0, 1, "read hang");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp, "read data");
    chk(r, 2'b00, "read response");
  endtask

  task automatic setwr(input logic [7:0] w, input logic [7:0] s);
    wr(8'h00, {24'h0, w});
    wr(8'h04, {24'h0, s});
  endtask

  task automatic exec(input logic [15:0] w);
    int n;
    iword <= w;
    ivalid <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk);
      if (iready) break;
    end
    ivalid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h0C, 32'h0);
    rd(8'h10, d, r);
    chk(r, 2'b10, "unmapped response");
    chk(d, 32'h0, "unmapped data");
  endtask

  task automatic t_add_literal;
    logic [31:0] tv [3] = '{32'h10152500, 32'h7F01801A, 32'hFF010007};
    foreach (tv[i]) begin
      setwr(tv[i][31:24], 8'h00);
      exec({aaie_pkg::OPC_ADD_LITERAL, tv[i][23:16]});
      rd_chk(8'h00, {24'h0, tv[i][15:8]});
      rd_chk(8'h04, {24'h0, tv[i][7:0]});
    end
  endtask

  task automatic t_add_file;
    wr(8'h08, 32'h3);
    setwr(8'h17, 8'h00);
    aaie_dmem_model_i.mem[12'h042] = 8'hC2;
    aaie_dmem_model_i.mem[12'h320] = 8'h01;
    exec(16'h2442);
    exec(16'h2720);
    rd_chk(8'h00, 32'hD9);
    rd_chk(8'h04, 32'h10);
    chk(aaie_dmem_model_i.mem[12'h042], 8'hC2, "file kept");
    chk(aaie_dmem_model_i.mem[12'h320], 8'hDA, "file sum");
  endtask

  task automatic t_add_carry;
    setwr(8'h4D, 8'h01);
    aaie_dmem_model_i.mem[12'hF90] = 8'h02;
    exec(16'h2090);
    rd_chk(8'h00, 32'h50);
    rd_chk(8'h04, 32'h02);
    exec(16'h2290);
    rd_chk(8'h04, 32'h00);
    chk(aaie_dmem_model_i.mem[12'hF90], 8'h52, "carry sum");
  endtask

  task automatic t_and_ops;
    setwr(8'hA3, 8'h0B);
    exec(16'h0B5F);
    rd_chk(8'h00, 32'h03);
    rd_chk(8'h04, 32'h0B);
    exec(16'h0B00);
    rd_chk(8'h04, 32'h0F);
    setwr(8'h17, 8'h0B);
    aaie_dmem_model_i.mem[12'hFC2] = 8'hC2;
    aaie_dmem_model_i.mem[12'h310] = 8'h9C;
    exec(16'h14C2);
    rd_chk(8'h00, 32'h02);
    rd_chk(8'h04, 32'h0B);
    setwr(8'hF0, 8'h0B);
    exec(16'h1710);
    rd_chk(8'h00, 32'hF0);
    rd_chk(8'h04, 32'h1B);
    chk(aaie_dmem_model_i.mem[12'h310], 8'h90, "and result");
  endtask

  task automatic t_unknown;
    exec(16'hFFFF);
    rd_chk(8'h0C, 32'h0000_9002);
    wr(8'h0C, 32'h0000_0002);
    rd_chk(8'h0C, 32'h0000_9000);
  endtask

  task automatic final_report;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    final_report;
  end

  initial begin
    rst = 1'b1;
    {awaddr, araddr, wdata, iword} = '0;
    {awvalid, wvalid, bready, arvalid, rready, ivalid} = '0;
    wstrb = 4'hF;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_add_literal;
    t_add_file;
    t_add_carry;
    t_and_ops;
    t_unknown;
    final_report;
  end
endmodule

`default_nettype wire
